// ==== logic/partial_numerator_div_pkg.sv ====
// Constants for the fractional-N divider control block.
// Assumes a single 200 MHz clock domain and an AXI4-Lite register bus.
package partial_numerator_div_pkg;
   localparam int unsigned CLK_MHZ        = 200;
   // Register byte offsets
   localparam logic [7:0] OFS_WHOLE       = 8'h00;
   localparam logic [7:0] OFS_NUMER       = 8'h04;
   localparam logic [7:0] OFS_REFDIV      = 8'h08;
   localparam logic [7:0] OFS_CONTROL     = 8'h0c;
   localparam logic [7:0] OFS_STATUS      = 8'h10;
   localparam logic [7:0] OFS_LENGTH      = 8'h14;
   // Field widths and positions
   localparam int unsigned WHOLE_W        = 16;
   localparam int unsigned PARTIAL_NUMERATOR_W         = 12;
   localparam int unsigned RDIV_W         = 4;
   localparam int unsigned RDIV_DEN_LSB   = 4;
   localparam int unsigned CTL_DOUBLER    = 0;
   localparam int unsigned CTL_FASTLOCK   = 1;
   localparam int unsigned CTL_MODE_LSB   = 2;
   localparam int unsigned CTL_CP_LSB     = 4;
   localparam int unsigned CTL_MON_LSB    = 8;
   localparam int unsigned CP_W           = 4;
   localparam int unsigned MON_W          = 3;
   localparam int unsigned DITHER_LOG     = 21;
   // Bounds and reset values
   localparam logic [11:0] DEN_MIN        = 12'h002;
   localparam logic [11:0] DEN_MAX        = 12'hfff;
   localparam logic [11:0] DEN_RESET      = 12'h002;
   localparam logic [3:0]  RDIV_MIN       = 4'h1;
   localparam logic [3:0]  RDIV_RESET     = 4'h1;
   localparam logic [15:0] WHOLE_RESET    = 16'h001f;
   localparam logic [3:0]  CP_MAX         = 4'hf;
   localparam logic [3:0]  CP_MIN         = 4'h0;
   localparam logic [2:0]  MON_FASTLOCK   = 3'h5;
   localparam logic [1:0]  RESP_OKAY      = 2'b00;
   localparam logic [1:0]  RESP_SLVERR    = 2'b10;
   typedef enum logic [1:0] {MODE_LOWEST_NOISE, MODE_LOW_NOISE_SPUR,
                             MODE_RSVD, MODE_LOW_SPUR} mode_e;
endpackage

// ==== logic/partial_numerator_div_ctrl.sv ====
// Fractional-N divider control: registers, reference divider, third-order
// sigma-delta modulator and fastlock. Assumes reference_clock_in comes from a
// pin and is sampled on aclk; the modulator output goes to an external divider.
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps

// Overview of operation
// RQ1 - Divide ratio presented each reference cycle averages whole + numerator/denominator.
// RQ2 - Reference tick rate is input rate times one plus doubler, divided by the ratio.
// RQ3 - Denominator accepts any value from 2 to 4095 in twelve bits.
// RQ4 - Host keeps the denominator at 50 or more when the low-spur dithered mode is used.
// RQ5 - Modulator is third order and steps once per reference tick.
// RQ6 - Undithered repeat length is denominator times 2, 3, 6 or 1 by divisibility.
// RQ7 - Dithered repeat length is two to the twenty-first cycles.
// RQ8 - Fastlock set drives the charge pump at maximum current while it stays set.
// RQ9 - Host selects the fastlock switch function on the monitor pin to use the switch.
// RQ10 - Fastlock clear returns the pump to lowest current and opens the switch.
// RQ11 - Host picks the denominator as reference rate over channel resolution.
// RQ12 - Host keeps the reference tick rate within the modulator speed limit.
// RQ13 - A new denominator is used only after a reference-divider write then a whole write.
// RQ14 - Dither is on in low-spur mode and off in the two low-noise modes.
// RQ15 - Reference counter divides by 1 to 15.
// RQ16 - New whole, numerator and denominator values apply at a reference tick boundary.
module partial_numerator_div_ctrl (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        reference_clock_in,
   output logic             pfd_tick,
   output logic [15:0]      divide_value,
   output logic [3:0]       cp_current,
   output logic             loop_switch_closed,
   output logic [2:0]       monitor_pin_select
);

   function automatic logic [11:0] lanes12(input logic [11:0] old, input logic [31:0] wd,
                                           input logic [3:0] st, input int unsigned lsb);
      logic [31:0] sh;
      sh = wd >> lsb;
      lanes12 = old;
      if (st[0]) lanes12[7:0] = sh[7:0];
      if (st[1]) lanes12[11:8] = sh[11:8];
   endfunction

   // Bus and register state
   logic        aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_q, bvalid_d;
   logic        rvalid_q, rvalid_d;
   logic [7:0]  awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
   logic [3:0]  wstrb_q, wstrb_d;
   logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
   logic [15:0] whole_q, whole_d;
   logic [11:0] numer_q, numer_d, den_stage_q, den_stage_d, den_latch_q, den_latch_d;
   logic [3:0]  rdiv_q, rdiv_d, cp_set_q, cp_set_d;
   logic        doubler_q, doubler_d, fastlock_q, fastlock_d, pend_q, pend_d;
   logic [1:0]  mode_q, mode_d;
   logic [2:0]  mon_q, mon_d;
   // Active values, swapped only at a tick
   logic [15:0] whole_a_q, whole_a_d;
   logic [11:0] numer_a_q, numer_a_d, den_a_q, den_a_d;
   logic        upd_q, upd_d;
   // Reference path
   logic        ref_s1_q, ref_s2_q, ref_s3_q;
   logic [3:0]  rcnt_q, rcnt_d;
   logic        tick_q, tick_d;
   // Modulator
   logic [12:0] acc1_q, acc1_d, acc2_q, acc2_d, acc3_q, acc3_d;
   logic        c2_q, c2_d, c3_q, c3_d, c3p_q, c3p_d;
   logic [20:0] lfsr_q, lfsr_d;
   logic [15:0] divv_q, divv_d;
   logic [3:0]  cp_q, cp_d;
   logic        sw_q, sw_d;

   logic        wr_go, rd_go;
   logic        ref_edge;
   logic [31:0] rlen;

   assign wr_go = aw_have_q && w_have_q && !bvalid_q;
   assign rd_go = s_axi_arvalid && !rvalid_q;
   // Doubler makes both edges active, else only the falling edge
   assign ref_edge = doubler_q ? (ref_s2_q ^ ref_s3_q) : (ref_s3_q && !ref_s2_q); // see RQ2

   // Repeat length shown to software
   always_comb begin
      if (mode_q == partial_numerator_div_pkg::MODE_LOW_SPUR) begin
         rlen = 32'h1 << partial_numerator_div_pkg::DITHER_LOG; // see RQ7
      end else if (den_a_q % 12'd6 == 12'd0) begin
         rlen = {20'h0, den_a_q} * 32'd6; // see RQ6
      end else if (den_a_q % 12'd3 == 12'd0) begin
         rlen = {20'h0, den_a_q} * 32'd3;
      end else if (den_a_q[0] == 1'b0) begin
         rlen = {20'h0, den_a_q} * 32'd2;
      end else begin
         rlen = {20'h0, den_a_q};
      end
   end

   // Register bus
   always_comb begin
      aw_have_d = aw_have_q; w_have_d = w_have_q; awaddr_d = awaddr_q;
      wdata_d = wdata_q; wstrb_d = wstrb_q; bvalid_d = bvalid_q; bresp_d = bresp_q;
      rvalid_d = rvalid_q; rdata_d = rdata_q; rresp_d = rresp_q;
      whole_d = whole_q; numer_d = numer_q; den_stage_d = den_stage_q;
      den_latch_d = den_latch_q; rdiv_d = rdiv_q; doubler_d = doubler_q;
      fastlock_d = fastlock_q; mode_d = mode_q; cp_set_d = cp_set_q; mon_d = mon_q;
      pend_d = pend_q; upd_d = upd_q;
      if (s_axi_awvalid && !aw_have_q) begin
         aw_have_d = 1'b1;
         awaddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have_q) begin
         w_have_d = 1'b1;
         wdata_d = s_axi_wdata;
         wstrb_d = s_axi_wstrb;
      end
      if (bvalid_q && s_axi_bready) bvalid_d = 1'b0;
      // Clear first; a write in the swap cycle must keep its update request
      if (tick_q && upd_q) upd_d = 1'b0;
      if (wr_go) begin
         aw_have_d = 1'b0;
         w_have_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = partial_numerator_div_pkg::RESP_OKAY;
         if (awaddr_q == partial_numerator_div_pkg::OFS_WHOLE) begin
            if (wstrb_q[0]) whole_d[7:0] = wdata_q[7:0];
            if (wstrb_q[1]) whole_d[15:8] = wdata_q[15:8];
            if (wstrb_q[2]) fastlock_d = wdata_q[16]; // see RQ8
            den_latch_d = den_stage_q; // see RQ13
            pend_d = 1'b0;
            upd_d = 1'b1;
         end else if (awaddr_q == partial_numerator_div_pkg::OFS_NUMER) begin
            numer_d = lanes12(numer_q, wdata_q, wstrb_q, 0);
            upd_d = 1'b1;
         end else if (awaddr_q == partial_numerator_div_pkg::OFS_REFDIV) begin
            // Ratio 0 is refused and kept at its last legal value
            if (wstrb_q[0] && wdata_q[3:0] >= partial_numerator_div_pkg::RDIV_MIN) begin
               rdiv_d = wdata_q[3:0]; // see RQ15
            end
            den_stage_d = lanes12(den_stage_q, wdata_q, wstrb_q, 0) ;
            if (wstrb_q[0] || wstrb_q[1]) begin
               den_stage_d = wdata_q[15:4] < partial_numerator_div_pkg::DEN_MIN ? den_stage_q
                                                                   : wdata_q[15:4]; // see RQ3
            end
            pend_d = 1'b1;
         end else if (awaddr_q == partial_numerator_div_pkg::OFS_CONTROL) begin
            if (wstrb_q[0]) begin
               doubler_d = wdata_q[partial_numerator_div_pkg::CTL_DOUBLER];
               mode_d = wdata_q[partial_numerator_div_pkg::CTL_MODE_LSB +: 2];
               cp_set_d[3:0] = wdata_q[partial_numerator_div_pkg::CTL_CP_LSB +: partial_numerator_div_pkg::CP_W];
            end
            if (wstrb_q[1]) mon_d = wdata_q[partial_numerator_div_pkg::CTL_MON_LSB +: partial_numerator_div_pkg::MON_W];
         end else if (awaddr_q != partial_numerator_div_pkg::OFS_STATUS &&
                      awaddr_q != partial_numerator_div_pkg::OFS_LENGTH) begin
            bresp_d = partial_numerator_div_pkg::RESP_SLVERR;
         end
      end
      if (rvalid_q && s_axi_rready) rvalid_d = 1'b0;
      if (rd_go) begin
         rvalid_d = 1'b1;
         rresp_d = partial_numerator_div_pkg::RESP_OKAY;
         if (s_axi_araddr == partial_numerator_div_pkg::OFS_WHOLE) begin
            rdata_d = {15'h0, fastlock_q, whole_q};
         end else if (s_axi_araddr == partial_numerator_div_pkg::OFS_NUMER) begin
            rdata_d = {20'h0, numer_q};
         end else if (s_axi_araddr == partial_numerator_div_pkg::OFS_REFDIV) begin
            rdata_d = {16'h0, den_stage_q, rdiv_q};
         end else if (s_axi_araddr == partial_numerator_div_pkg::OFS_CONTROL) begin
            rdata_d = {21'h0, mon_q, cp_set_q, mode_q, 1'b0, doubler_q};
         end else if (s_axi_araddr == partial_numerator_div_pkg::OFS_STATUS) begin
            rdata_d = {3'h0, pend_q, den_a_q, whole_a_q};
         end else if (s_axi_araddr == partial_numerator_div_pkg::OFS_LENGTH) begin
            rdata_d = rlen;
         end else begin
            rdata_d = 32'h0;
            rresp_d = partial_numerator_div_pkg::RESP_SLVERR;
         end
      end
   end

   // Reference divider and modulator
   always_comb begin
      logic [12:0] s1, s2, s3;
      logic [12:0] dth;
      logic signed [17:0] mash;
      s1 = '0; s2 = '0; s3 = '0; dth = '0; mash = '0;
      rcnt_d = rcnt_q; tick_d = 1'b0;
      whole_a_d = whole_a_q; numer_a_d = numer_a_q; den_a_d = den_a_q;
      acc1_d = acc1_q; acc2_d = acc2_q; acc3_d = acc3_q;
      c2_d = c2_q; c3_d = c3_q; c3p_d = c3p_q; lfsr_d = lfsr_q; divv_d = divv_q;
      if (ref_edge) begin
         if (rcnt_q + 4'h1 >= rdiv_q) begin
            rcnt_d = 4'h0;
            tick_d = 1'b1; // see RQ2
         end else begin
            rcnt_d = rcnt_q + 4'h1;
         end
      end
      if (tick_q) begin
         // Swap whole set at once; avoids a mixed divide cycle
         if (upd_q) begin
            whole_a_d = whole_q; // see RQ16
            numer_a_d = numer_q;
            den_a_d = den_latch_q; // see RQ13
         end
         // Dither perturbs the first stage LSB; 21-bit LFSR gives the long period
         if (mode_q == partial_numerator_div_pkg::MODE_LOW_SPUR) begin
            lfsr_d = {lfsr_q[19:0], lfsr_q[20] ^ lfsr_q[18]}; // see RQ7
            dth = {12'h0, lfsr_q[0]}; // see RQ14
         end
         // Three cascaded modulo-denominator accumulators (MASH 1-1-1)
         s1 = acc1_q + {1'b0, numer_a_q} + dth; // see RQ5
         acc1_d = s1 >= {1'b0, den_a_q} ? s1 - {1'b0, den_a_q} : s1;
         s2 = acc2_q + acc1_d;
         c2_d = s2 >= {1'b0, den_a_q};
         acc2_d = c2_d ? s2 - {1'b0, den_a_q} : s2;
         s3 = acc3_q + acc2_d;
         c3_d = s3 >= {1'b0, den_a_q};
         acc3_d = c3_d ? s3 - {1'b0, den_a_q} : s3;
         c3p_d = c3_q;
         mash = 18'(s1 >= {1'b0, den_a_q}) + 18'(c2_d) - 18'(c2_q)
                + 18'(c3_d) - 18'(2 * c3_q) + 18'(c3p_q);
         divv_d = 16'(18'(whole_a_q) + mash); // see RQ1
         // Fresh state per new setting; old residues may exceed a smaller denominator
         if (upd_q) begin
            acc1_d = 13'h0; // see RQ16
            acc2_d = 13'h0;
            acc3_d = 13'h0;
            c2_d = 1'b0;
            c3_d = 1'b0;
            c3p_d = 1'b0;
         end
      end
   end

   // Fastlock drives pump and switch
   always_comb begin
      // Next values, so pump, switch and monitor select move on one edge
      cp_d = fastlock_d ? partial_numerator_div_pkg::CP_MAX : partial_numerator_div_pkg::CP_MIN; // see RQ8
      // Switch follows fastlock only on the switch monitor selection
      sw_d = fastlock_d && (mon_d == partial_numerator_div_pkg::MON_FASTLOCK); // see RQ10
   end

   always_ff @(posedge aclk) begin
      ref_s1_q <= reference_clock_in;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
      if (!aresetn) begin
         aw_have_q <= 1'b0; w_have_q <= 1'b0; awaddr_q <= 8'h00; wdata_q <= 32'h0;
         wstrb_q <= 4'h0; bvalid_q <= 1'b0; bresp_q <= 2'b00; rvalid_q <= 1'b0;
         rdata_q <= 32'h0; rresp_q <= 2'b00;
         whole_q <= partial_numerator_div_pkg::WHOLE_RESET; numer_q <= 12'h000;
         den_stage_q <= partial_numerator_div_pkg::DEN_RESET; den_latch_q <= partial_numerator_div_pkg::DEN_RESET;
         rdiv_q <= partial_numerator_div_pkg::RDIV_RESET; doubler_q <= 1'b0; fastlock_q <= 1'b0;
         mode_q <= 2'b00; cp_set_q <= 4'h0; mon_q <= 3'h0; pend_q <= 1'b0; upd_q <= 1'b1;
         whole_a_q <= partial_numerator_div_pkg::WHOLE_RESET; numer_a_q <= 12'h000;
         den_a_q <= partial_numerator_div_pkg::DEN_RESET;
         rcnt_q <= 4'h0; tick_q <= 1'b0;
         acc1_q <= 13'h0; acc2_q <= 13'h0; acc3_q <= 13'h0;
         c2_q <= 1'b0; c3_q <= 1'b0; c3p_q <= 1'b0; lfsr_q <= 21'h000001;
         divv_q <= partial_numerator_div_pkg::WHOLE_RESET; cp_q <= 4'h0; sw_q <= 1'b0;
      end else begin
         aw_have_q <= aw_have_d; w_have_q <= w_have_d; awaddr_q <= awaddr_d;
         wdata_q <= wdata_d; wstrb_q <= wstrb_d; bvalid_q <= bvalid_d; bresp_q <= bresp_d;
         rvalid_q <= rvalid_d; rdata_q <= rdata_d; rresp_q <= rresp_d;
         whole_q <= whole_d; numer_q <= numer_d; den_stage_q <= den_stage_d;
         den_latch_q <= den_latch_d; rdiv_q <= rdiv_d; doubler_q <= doubler_d;
         fastlock_q <= fastlock_d; mode_q <= mode_d; cp_set_q <= cp_set_d; mon_q <= mon_d;
         pend_q <= pend_d; upd_q <= upd_d;
         whole_a_q <= whole_a_d; numer_a_q <= numer_a_d; den_a_q <= den_a_d;
         rcnt_q <= rcnt_d; tick_q <= tick_d;
         acc1_q <= acc1_d; acc2_q <= acc2_d; acc3_q <= acc3_d;
         c2_q <= c2_d; c3_q <= c3_d; c3p_q <= c3p_d; lfsr_q <= lfsr_d;
         divv_q <= divv_d; cp_q <= cp_d; sw_q <= sw_d;
      end
   end

   assign s_axi_awready      = !aw_have_q;
   assign s_axi_wready       = !w_have_q;
   assign s_axi_bvalid       = bvalid_q;
   assign s_axi_bresp        = bresp_q;
   assign s_axi_arready      = !rvalid_q;
   assign s_axi_rvalid       = rvalid_q;
   assign s_axi_rdata        = rdata_q;
   assign s_axi_rresp        = rresp_q;
   assign pfd_tick           = tick_q;
   assign divide_value       = divv_q;
   assign cp_current         = cp_q;
   assign loop_switch_closed = sw_q;
   assign monitor_pin_select = mon_q;

endmodule

// ==== testbench/ref_src.sv ====
// Reference pin source standing in for the board oscillator.
// Assumes the bench picks a half period of several aclk periods.
`timescale 1ns/10ps
module ref_src #(
   parameter real HALF = 20.0
) (
   output logic ref_out
);
   // Free running; offset keeps edges away from aclk edges
   initial begin
      ref_out = 1'b0;
      #1.3;
      forever #HALF ref_out = ~ref_out;
   end
endmodule

// ==== testbench/partial_numerator_div_ctrl_chk.sv ====
// Port assertions for the divider control block.
// Assumes one aclk domain with synchronous active-low aresetn.
`timescale 1ns/10ps
module partial_numerator_div_ctrl_chk (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        pfd_tick,
   input wire logic [15:0] divide_value,
   input wire logic [3:0]  cp_current,
   input wire logic        loop_switch_closed,
   input wire logic [2:0]  monitor_pin_select
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence wr_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence b_answer;
      ##[1:3] s_axi_bvalid;
   endsequence
   sequence pump_high;
      cp_current == partial_numerator_div_pkg::CP_MAX;
   endsequence
   // Only joint address and data hand-overs are timed here
   AST_WR_RESP: assert property (wr_both |-> b_answer)
      else $error("write response late");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
   AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && !s_axi_arready) else $error("read response late");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
   AST_TICK_PULSE: assert property (pfd_tick |=> !pfd_tick)
      else $error("tick too long");
   // Past reset guard: a short reset pulse reloads the ratio
   AST_DIV_AT_TICK: assert property ($past(aresetn) && $changed(divide_value)
      |-> $past(pfd_tick)) else $error("divide changed off tick");
   AST_CP_LEVELS: assert property (cp_current == partial_numerator_div_pkg::CP_MAX
      || cp_current == partial_numerator_div_pkg::CP_MIN) else $error("pump level");
   AST_SWITCH: assert property (loop_switch_closed |-> pump_high
      and monitor_pin_select == partial_numerator_div_pkg::MON_FASTLOCK) else $error("switch");
   AST_FL_OFF: assert property ($fell(cp_current == partial_numerator_div_pkg::CP_MAX)
      |-> !loop_switch_closed) else $error("switch left closed");
endmodule
bind partial_numerator_div_ctrl partial_numerator_div_ctrl_chk i_chk (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .pfd_tick(pfd_tick), .divide_value(divide_value), .cp_current(cp_current),
   .loop_switch_closed(loop_switch_closed), .monitor_pin_select(monitor_pin_select));

// ==== testbench/tb_partial_numerator_div_ctrl.sv ====
// Self-checking bench for the divider control block.
// Assumes the reference model drives the pin and the checker is bound.
`timescale 1ns/10ps
module tb_partial_numerator_div_ctrl;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic        awvalid = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic [7:0]  araddr = 8'h00;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, ref_clk, tick, sw;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [15:0] div;
   logic [3:0]  cp;
   logic [2:0]  mon;
   int          n_fail = 0;
   int          compares = 0;
   always #2.5 aclk = ~aclk;
   // Four aclk cycles per reference half period
   ref_src #(.HALF(20.0)) i_ref (.ref_out(ref_clk));
   partial_numerator_div_ctrl i_dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .reference_clock_in(ref_clk), .pfd_tick(tick), .divide_value(div),
      .cp_current(cp), .loop_switch_closed(sw), .monitor_pin_select(mon));
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic guard(input int k, input int lim);
      if (k >= lim) begin
         n_fail++;
         report_and_stop();
      end
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int k = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         k++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid && k < 200);
      r = bresp;
      bready <= 1'b0;
      guard(k, 200);
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int k = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         k++;
         if (arready) arvalid <= 1'b0;
      end while (!rvalid && k < 200);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      guard(k, 200);
   endtask
   task automatic ticks(input int n, output int k);
      k = 0;
      repeat (n) do begin
         @(posedge aclk);
         k++;
      end while (!tick && k < 9000);
      guard(k, 9000);
   endtask
   function automatic logic [31:0] exp_len(input int d, input int m);
      if (m == 3) return 32'h0020_0000;
      if (d % 6 == 0) return 6 * d;
      if (d % 3 == 0) return 3 * d;
      if (d % 2 == 0) return 2 * d;
      return d;
   endfunction
   initial begin
      int k, w, f, act;
      int rs[4] = '{1, 3, 15, 0};
      int ds[4] = '{1, 0, 0, 0};
      int dens[7] = '{10, 9, 12, 125, 4095, 1, 0};
      int mds[7] = '{0, 1, 0, 3, 1, 0, 3};
      int fls[3] = '{1, 0, 1};
      int mns[3] = '{5, 5, 2};
      logic [31:0] d;
      logic [1:0] r;
      logic signed [31:0] sum;
      void'($urandom(5));
      act = 2;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      #1;
      chk("divide reset", 32'h1f, div);
      chk("pump reset", 32'h0, {cp, sw});
      axi_rd(partial_numerator_div_pkg::OFS_STATUS, d, r);
      chk("status reset", 32'h0002_001f, d);
      axi_rd(8'h40, d, r);
      chk("unmapped read", {30'h0, partial_numerator_div_pkg::RESP_SLVERR}, {d[29:0], r});
      axi_wr(8'h40, 32'h0, r);
      chk("unmapped write", partial_numerator_div_pkg::RESP_SLVERR, r);
      // Ratio 0 is refused, so the last step keeps divide-by-15
      for (int i = 0; i < 4; i++) begin
         axi_wr(partial_numerator_div_pkg::OFS_CONTROL, ds[i], r);
         axi_wr(partial_numerator_div_pkg::OFS_REFDIV, {16'h0, 12'h002, rs[i][3:0]}, r);
         ticks(2, k);
         ticks(4, k);
         chk("tick spacing", 32 * (rs[i] == 0 ? 15 : rs[i]) / (1 + ds[i]), k);
      end
      dens[6] = $urandom_range(4095, 50);
      for (int i = 0; i < 7; i++) begin
         axi_wr(partial_numerator_div_pkg::OFS_CONTROL, {28'h0, mds[i][1:0], 2'h0}, r);
         axi_wr(partial_numerator_div_pkg::OFS_REFDIV, {16'h0, dens[i][11:0], 4'h1}, r);
         axi_rd(partial_numerator_div_pkg::OFS_STATUS, d, r);
         // Any ratio write marks a pending denominator, even a refused one
         chk("staged", {19'h0, 1'b1, act[11:0]}, {19'h0, d[28:16]});
         w = $urandom_range(4000, 31);
         axi_wr(partial_numerator_div_pkg::OFS_WHOLE, w, r);
         if (dens[i] > 1) act = dens[i];
         ticks(2, k);
         axi_rd(partial_numerator_div_pkg::OFS_STATUS, d, r);
         chk("active", {4'h0, act[11:0], w[15:0]}, {4'h0, d[27:0]});
         axi_rd(partial_numerator_div_pkg::OFS_LENGTH, d, r);
         chk("repeat length", exp_len(act, mds[i]), d);
      end
      f = $urandom_range(9, 1);
      axi_wr(partial_numerator_div_pkg::OFS_CONTROL, 32'h0, r);
      axi_wr(partial_numerator_div_pkg::OFS_REFDIV, 32'h00a1, r);
      axi_wr(partial_numerator_div_pkg::OFS_NUMER, f, r);
      axi_wr(partial_numerator_div_pkg::OFS_WHOLE, w, r);
      ticks(3, k);
      sum = 0;
      repeat (100) begin
         ticks(1, k);
         #1;
         sum += div;
      end
      // Third-order shaping bounds the running error to a few units
      sum = sum - 100 * w - 10 * f;
      chk("mean divide", 32'h1, sum >= -4 && sum <= 4);
      for (int i = 0; i < 3; i++) begin
         axi_wr(partial_numerator_div_pkg::OFS_CONTROL, {21'h0, mns[i][2:0], 8'h0}, r);
         axi_wr(partial_numerator_div_pkg::OFS_WHOLE, {15'h0, fls[i][0], w[15:0]}, r);
         k = 0;
         while (cp !== (fls[i] ? 4'hf : 4'h0) && k < 20) begin
            @(posedge aclk);
            k++;
         end
         guard(k, 20);
         #1;
         chk("pump", fls[i] ? 32'hf : 32'h0, cp);
         chk("switch", fls[i] == 1 && mns[i] == 5, sw);
         chk("monitor", mns[i], mon);
      end
      report_and_stop();
   end
endmodule
